// >>> wdg_consts.vh
`ifndef WDG_CONSTS_VH
`define WDG_CONSTS_VH

// register map on the internal processor bus
`define WDG_ADDR_SERVICE 16'hFFFF
`define WDG_ADDR_OPT_LO 16'h001E
`define WDG_ADDR_OPT_HI 16'h001F

// option latch layout, high latch
`define WDG_OPT_DISABLE 0
`define WDG_OPT_STOP_EN 1
`define WDG_OPT_SHORT_REC 2
`define WDG_OPT_VOLT_MODE 3
`define WDG_OPT_MON_PWRD 4
`define WDG_OPT_MON_RSTD 5
`define WDG_OPT_MON_STOP 6
`define WDG_OPT_RATE 7
// option latch layout, low latch
`define WDG_OPT_OSC_STOP 0
`define WDG_OPT_RESET 8'h00

// watchdog chain
`define WDG_PRE_W 12
`define WDG_CNT_W 6
`define WDG_CNT_FULL 6'h3F
`define WDG_PRE_CLR_MASK 12'h00F
`define WDG_PRE_ZERO 12'h000
`define WDG_CNT_ZERO 6'h00
`define WDG_FAST_TAP 6
`define WDG_FAST_END 7'h70
`define WDG_SLOW_END 12'hFF0
`define WDG_FAST_LOW_W 7

// reset pulse and recovery delays, in clock ticks
`define WDG_RST_TICKS 6'h20
`define WDG_POR_CYCLES 13'h1000
`define WDG_REC_SHORT 13'h0020
`define WDG_REC_LONG 13'h1000
`define WDG_DLY_W 13

`endif

// >>> wdg_core.v
`timescale 1ns/1ns
`include "wdg_consts.vh"

// prescaler plus six-bit counter; advances once per watchdog clock tick
module wdg_core (
    input wire core_clk,
    input wire reset,
    input wire tick,
    input wire clear_all,
    input wire clear_prescaler,
    input wire service,
    input wire rate_fast,
    output reg overflow
);
    reg [`WDG_PRE_W-1:0] prescaler;
    reg [`WDG_CNT_W-1:0] counter;
    wire slow_carry;
    wire fast_carry;
    wire carry;
    wire at_end;

    // prescaler tap picked by rate so both timeouts come out exact
    assign slow_carry = &prescaler;
    assign fast_carry = &prescaler[`WDG_FAST_TAP:0];
    assign carry = rate_fast ? fast_carry : slow_carry;
    // end point sits 16 ticks short of the full wrap
    assign at_end = (counter == `WDG_CNT_FULL) &&
        (rate_fast ? (prescaler[`WDG_FAST_LOW_W-1:0] == `WDG_FAST_END) : (prescaler == `WDG_SLOW_END));

    // chain update; clears take priority over counting
    always @(posedge core_clk) begin
        overflow <= 1'b0;
        if (reset || clear_all) begin
            prescaler <= `WDG_PRE_ZERO;
            counter <= `WDG_CNT_ZERO;
        end else if (service) begin
            prescaler <= prescaler & `WDG_PRE_CLR_MASK;
            counter <= `WDG_CNT_ZERO;
        end else if (clear_prescaler) begin
            prescaler <= `WDG_PRE_ZERO;
        end else if (tick) begin
            if (at_end) begin
                overflow <= 1'b1;
                prescaler <= `WDG_PRE_ZERO;
                counter <= `WDG_CNT_ZERO;
            end else begin
                prescaler <= prescaler + 1'b1;
                if (carry) begin
                    counter <= counter + 1'b1;
                end
            end
        end
    end
endmodule

// >>> wdg_top.v
`timescale 1ns/1ns
`include "wdg_consts.vh"

// What this block does
// - six-bit counter fed by carry of twelve-bit prescaler, both on watchdog clock
// - overflow resets device; 8176 ticks with fast rate, 262128 with slow
// - any write to service location clears counter and upper prescaler stages
// - reading service location returns reset vector low byte, not watchdog state
// - overflow drives reset pin low 32 ticks and sets watchdog reset flag
// - stop instruction clears prescaler when stop-enable set; watchdog clock gated during stop
// - prescaler cleared 4096 oscillator cycles after power-up
// - any internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - disable option set means watchdog never resets; clear means enabled
// - monitor mode disables watchdog under test voltage, or until power-on if blank
// - during break, test voltage on reset pin disables watchdog
// - watchdog keeps counting in wait mode
// - watchdog raises no processor interrupt; reset is its only action
// - stop with stop-enable clear is illegal opcode reset, else enters stop
// - stop exit delay 32 oscillator cycles if short recovery set, else 4096
// - stop exit by low-voltage reset always uses long delay
// - oscillator-in-stop set or reset pin level high keeps clocks running in stop, else forced low
// - monitor runs in stop only if in-stop set and power-down clear
// - reset-disable suppresses monitor reset; power-disable powers monitor down
// - voltage mode option cleared only by power-on reset
// - option latches write once after reset, cleared by reset, always readable
// - option latches sit at 0x001E and 0x001F
module wdg_top (
    input wire core_clk,
    input wire reset,
    input wire internal_reset,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_write,
    input wire bus_read,
    output reg [7:0] bus_rdata,
    input wire [7:0] reset_vector_low,
    input wire vector_fetch,
    input wire watchdog_clock,
    input wire stop_exec,
    input wire wake_request,
    input wire monitor_mode,
    input wire monitor_blank_entry,
    input wire break_active,
    input wire irq_test_voltage,
    input wire rst_test_voltage,
    input wire monitor_trip,
    input wire reset_pin_in,
    output reg reset_pin_out,
    output reg reset_pin_oe_n,
    output reg watchdog_reset_flag,
    output reg illegal_stop_reset,
    output reg stop_mode,
    output reg stop_exit_done,
    output reg gen_clock_run,
    output reg monitor_power_on,
    output reg monitor_reset_req
);
    localparam ST_RUN = 2'b00;
    localparam ST_STOP = 2'b01;
    localparam ST_RECOVER = 2'b10;

    reg [1:0] state;
    reg [7:0] opt_hi;
    reg [7:0] opt_lo;
    reg opt_hi_done;
    reg opt_lo_done;
    reg volt_mode;
    reg volt_done;
    reg blank_hold;
    reg [3:0] sync_a;
    reg [3:0] sync_b;
    reg wclk_prev;
    reg [12:0] por_count;
    reg por_pending;
    reg [`WDG_DLY_W-1:0] rec_count;
    reg [5:0] rst_ticks;
    reg rst_busy;
    wire any_reset;
    wire wclk_s;
    wire irq_tv;
    wire rst_tv;
    wire tick;
    wire tick_gated;
    wire disabled;
    wire service;
    wire clear_pre;
    wire overflow;
    wire mon_active;
    wire [7:0] opt_hi_view;
    wire rst_pin_s;

    // any reset of the device, including the watchdog's own pulse
    assign any_reset = reset | internal_reset | rst_busy;

    // two flip-flop synchronisers for pin-level inputs; stage one read only by stage two
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : pin_sync
            always @(posedge core_clk) begin
                sync_a[g] <= (g == 0) ? watchdog_clock : (g == 1) ? irq_test_voltage :
                    (g == 2) ? rst_test_voltage : reset_pin_in;
                sync_b[g] <= sync_a[g];
            end
        end
    endgenerate
    assign wclk_s = sync_b[0];
    assign irq_tv = sync_b[1];
    assign rst_tv = sync_b[2];
    // reset pad level, a pin like the others, so it goes through the same two stages
    assign rst_pin_s = sync_b[3];

    // rising edge of watchdog clock after synchronisation
    always @(posedge core_clk) begin
        if (reset) begin
            wclk_prev <= 1'b0;
        end else begin
            wclk_prev <= wclk_s;
        end
    end
    assign tick = wclk_s & ~wclk_prev;
    assign tick_gated = tick & (state == ST_RUN);

    // blank-vector monitor entry holds watchdog off until power-on reset
    always @(posedge core_clk) begin
        if (reset) begin
            blank_hold <= 1'b0;
        end else if (monitor_mode && monitor_blank_entry && !irq_tv) begin
            blank_hold <= 1'b1;
        end
    end

    // disable conditions; a disabled chain is held cleared
    assign disabled = opt_hi[`WDG_OPT_DISABLE]
        | (monitor_mode & (irq_tv | rst_tv)) | blank_hold
        | (break_active & rst_tv);

    assign service = bus_write && (bus_addr == `WDG_ADDR_SERVICE);
    assign clear_pre = vector_fetch
        | (stop_exec & opt_hi[`WDG_OPT_STOP_EN])
        | (por_pending && (por_count == `WDG_POR_CYCLES));

    wdg_core u_core (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick_gated),
        .clear_all(any_reset | disabled),
        .clear_prescaler(clear_pre),
        .service(service),
        .rate_fast(opt_hi[`WDG_OPT_RATE]),
        .overflow(overflow)
    );

    // power-up prescaler clear after the oscillator settles
    always @(posedge core_clk) begin
        if (reset) begin
            por_count <= 13'h0000;
            por_pending <= 1'b1;
        end else if (por_pending) begin
            if (por_count == `WDG_POR_CYCLES) begin
                por_pending <= 1'b0;
            end else begin
                por_count <= por_count + 1'b1;
            end
        end
    end

    // watchdog reset pulse, counted in watchdog clock ticks, not gated by stop
    always @(posedge core_clk) begin
        if (reset) begin
            rst_busy <= 1'b0;
            rst_ticks <= 6'h00;
            reset_pin_out <= 1'b1;
            reset_pin_oe_n <= 1'b1;
        end else if (overflow && !rst_busy) begin
            rst_busy <= 1'b1;
            rst_ticks <= 6'h00;
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= 1'b0;
        end else if (rst_busy && tick) begin
            if (rst_ticks == `WDG_RST_TICKS - 6'h01) begin
                rst_busy <= 1'b0;
                reset_pin_out <= 1'b1;
                reset_pin_oe_n <= 1'b1;
            end else begin
                rst_ticks <= rst_ticks + 1'b1;
            end
        end
    end

    // sticky watchdog reset flag; only power-on clears it
    always @(posedge core_clk) begin
        if (reset) begin
            watchdog_reset_flag <= 1'b0;
        end else if (overflow) begin
            watchdog_reset_flag <= 1'b1;
        end
    end

    // option latches; one write each per reset, lost writes simply ignored
    always @(posedge core_clk) begin
        if (any_reset) begin
            opt_hi <= `WDG_OPT_RESET;
            opt_lo <= `WDG_OPT_RESET;
            opt_hi_done <= 1'b0;
            opt_lo_done <= 1'b0;
        end else if (bus_write) begin
            if (bus_addr == `WDG_ADDR_OPT_HI && !opt_hi_done) begin
                opt_hi <= bus_wdata;
                opt_hi_done <= 1'b1;
            end
            if (bus_addr == `WDG_ADDR_OPT_LO && !opt_lo_done) begin
                opt_lo <= bus_wdata;
                opt_lo_done <= 1'b1;
            end
        end
    end

    // voltage mode survives all resets but power-on, one write per power-on
    always @(posedge core_clk) begin
        if (reset) begin
            volt_mode <= 1'b0;
            volt_done <= 1'b0;
        end else if (bus_write && bus_addr == `WDG_ADDR_OPT_HI && !volt_done) begin
            volt_mode <= bus_wdata[`WDG_OPT_VOLT_MODE];
            volt_done <= 1'b1;
        end
    end

    assign opt_hi_view = {opt_hi[7:`WDG_OPT_VOLT_MODE+1], volt_mode, opt_hi[`WDG_OPT_VOLT_MODE-1:0]};

    // read data, registered; service location never exposes chain state
    always @(posedge core_clk) begin
        if (reset) begin
            bus_rdata <= 8'h00;
        end else if (bus_read) begin
            case (bus_addr)
                `WDG_ADDR_SERVICE: bus_rdata <= reset_vector_low;
                `WDG_ADDR_OPT_HI: bus_rdata <= opt_hi_view;
                `WDG_ADDR_OPT_LO: bus_rdata <= opt_lo;
                default: bus_rdata <= 8'h00;
            endcase
        end
    end

    // stop entry, wake and recovery delay
    always @(posedge core_clk) begin
        illegal_stop_reset <= 1'b0;
        stop_exit_done <= 1'b0;
        if (reset || internal_reset) begin
            state <= ST_RUN;
            rec_count <= {`WDG_DLY_W{1'b0}};
        end else begin
            case (state)
                ST_RUN: begin
                    if (stop_exec) begin
                        if (opt_hi[`WDG_OPT_STOP_EN]) begin
                            state <= ST_STOP;
                        end else begin
                            illegal_stop_reset <= 1'b1;
                        end
                    end
                end
                ST_STOP: begin
                    if (monitor_reset_req) begin
                        // long delay regardless of short option
                        rec_count <= `WDG_REC_LONG;
                        state <= ST_RECOVER;
                    end else if (wake_request) begin
                        // relies on software: short delay assumes a running oscillator
                        rec_count <= opt_hi[`WDG_OPT_SHORT_REC] ? `WDG_REC_SHORT : `WDG_REC_LONG;
                        state <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    if (rec_count == {{(`WDG_DLY_W-1){1'b0}}, 1'b1}) begin
                        stop_exit_done <= 1'b1;
                        state <= ST_RUN;
                    end
                    rec_count <= rec_count - 1'b1;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // monitor live unless powered down: outside stop, or in stop when allowed
    assign mon_active = ~opt_hi[`WDG_OPT_MON_PWRD] & ((state == ST_RUN) | opt_hi[`WDG_OPT_MON_STOP]);

    // registered controls toward clock generator and low-voltage monitor
    always @(posedge core_clk) begin
        if (reset) begin
            stop_mode <= 1'b0;
            gen_clock_run <= 1'b1;
            monitor_power_on <= 1'b1;
            monitor_reset_req <= 1'b0;
        end else begin
            stop_mode <= (state != ST_RUN);
            gen_clock_run <= (state == ST_RUN) | opt_lo[`WDG_OPT_OSC_STOP] | rst_pin_s;
            monitor_power_on <= mon_active;
            monitor_reset_req <= monitor_trip & mon_active & ~opt_hi[`WDG_OPT_MON_RSTD];
        end
    end
endmodule

// >>> wdg_props.sv
`timescale 1ns/1ns
// port-level checker for the watchdog block, one clock domain
module wdg_chk (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] bus_addr,
    input wire logic bus_read,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] reset_vector_low,
    input wire logic stop_exec,
    input wire logic stop_mode,
    input wire logic stop_exit_done,
    input wire logic illegal_stop_reset,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic watchdog_reset_flag
);
    logic [7:0] low_cycles;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // cycles with the pin held low, saturating so a stuck pin cannot wrap
    always @(posedge core_clk) begin
        if (reset || reset_pin_out) begin
            low_cycles <= 8'h00;
        end else if (low_cycles != 8'hFF) begin
            low_cycles <= low_cycles + 8'h01;
        end
    end
    a_pin_enable_match: assert property (reset_pin_oe_n == reset_pin_out)
        else $error("reset pin enable and level disagree");
    a_pin_low_length: assert property ($rose(reset_pin_out) |-> low_cycles >= 8'h20)
        else $error("reset pin released too early");
    a_flag_with_pin: assert property ($rose(watchdog_reset_flag) |-> ##[0:2] !reset_pin_out)
        else $error("watchdog flag set without reset pin low");
    a_flag_stays_set: assert property (watchdog_reset_flag |=> watchdog_reset_flag)
        else $error("watchdog flag dropped without reset");
    a_vector_byte_read: assert property (bus_read && bus_addr == 16'hFFFF |=> bus_rdata == $past(reset_vector_low))
        else $error("service location read did not return vector byte");
    a_unmapped_zero: assert property (bus_read && bus_addr != 16'hFFFF && bus_addr != 16'h001E
        && bus_addr != 16'h001F |=> bus_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_illegal_one_cycle: assert property (illegal_stop_reset |=> !illegal_stop_reset)
        else $error("illegal stop pulse longer than one cycle");
    a_stop_answered: assert property (stop_exec && !stop_mode |-> ##[1:2] (stop_mode || illegal_stop_reset))
        else $error("stop instruction neither entered stop nor reset");
    a_exit_release: assert property (stop_exit_done |-> stop_mode ##[1:2] !stop_mode)
        else $error("stop mode not left after exit pulse");
endmodule

// >>> wdg_cpu_model.sv
`timescale 1ns/1ns
// processor side of the byte bus; strobes last exactly one edge
module wdg_cpu_model (
    input wire logic core_clk,
    input wire logic [7:0] bus_rdata,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_write,
    output logic bus_read
);
    // bus idle at time zero
    initial begin
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_write = 1'b0;
        bus_read = 1'b0;
    end
    // any data works for the service location, so callers pick it freely
    task bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge core_clk);
        bus_write <= 1'b0;
        bus_wdata <= ~d; // stale data must not look valid
    endtask
    // read data is registered, so it is taken a half cycle after the strobe edge
    task bus_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge core_clk);
        bus_read <= 1'b0;
        @(negedge core_clk);
        d = bus_rdata;
    endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ns
`include "wdg_consts.vh"
module tb;
    logic core_clk = 1'b0, reset = 1'b1, internal_reset = 1'b0, watchdog_clock = 1'b0;
    logic vector_fetch = 1'b0, stop_exec = 1'b0, wake_request = 1'b0, monitor_mode = 1'b0;
    logic irq_test_voltage = 1'b0, break_active = 1'b0, rst_tv = 1'b0, monitor_trip = 1'b0;
    logic [7:0] rv_low = 8'hA5, rd;
    wire [15:0] bus_addr;
    wire [7:0] bus_wdata, bus_rdata;
    wire bus_write, bus_read, reset_pin_out, reset_pin_oe_n, watchdog_reset_flag, illegal_stop_reset;
    wire stop_mode, stop_exit_done, gen_clock_run, monitor_power_on, monitor_reset_req;
    int mismatches = 0, checks_done = 0, ticks = 0;
    always #10 core_clk = ~core_clk;
    // slow pin clock, one tick per two core cycles; ticks feeds the timeout window
    always @(posedge core_clk) begin
        watchdog_clock <= ~watchdog_clock;
        if (watchdog_clock) ticks <= ticks + 1;
    end
    wdg_cpu_model u_wdg_cpu_model (.core_clk(core_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read));
    wdg_top u_wdg_top (.core_clk(core_clk), .reset(reset), .internal_reset(internal_reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .reset_vector_low(rv_low), .vector_fetch(vector_fetch),
        .watchdog_clock(watchdog_clock), .stop_exec(stop_exec), .wake_request(wake_request),
        .monitor_mode(monitor_mode), .monitor_blank_entry(1'b0), .break_active(break_active),
        .irq_test_voltage(irq_test_voltage), .rst_test_voltage(rst_tv), .monitor_trip(monitor_trip),
        .reset_pin_in(1'b0), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
        .watchdog_reset_flag(watchdog_reset_flag), .illegal_stop_reset(illegal_stop_reset),
        .stop_mode(stop_mode), .stop_exit_done(stop_exit_done), .gen_clock_run(gen_clock_run),
        .monitor_power_on(monitor_power_on), .monitor_reset_req(monitor_reset_req));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task wait_ticks(input int n);
        int t;
        t = ticks + n;
        while (ticks < t) @(negedge core_clk);
    endtask
    task pulse_stop;
        @(posedge core_clk);
        stop_exec <= 1'b1;
        @(posedge core_clk);
        stop_exec <= 1'b0;
    endtask
    // write-once latches, map and the vector overlap
    task t_options;
        u_wdg_cpu_model.bus_rd(16'h001F, rd);
        chk(rd, `WDG_OPT_RESET);
        u_wdg_cpu_model.bus_wr(16'h001E, 8'h01);
        u_wdg_cpu_model.bus_wr(16'h001F, 8'h8E);
        u_wdg_cpu_model.bus_wr(16'h001F, 8'h01);
        u_wdg_cpu_model.bus_rd(16'h001F, rd);
        chk(rd, 8'h8E);
        u_wdg_cpu_model.bus_rd(16'h001E, rd);
        chk(rd, 8'h01);
        u_wdg_cpu_model.bus_rd(`WDG_ADDR_SERVICE, rd);
        chk(rd, 8'hA5);
        @(posedge core_clk);
        rv_low <= 8'h3C;
        u_wdg_cpu_model.bus_rd(`WDG_ADDR_SERVICE, rd);
        chk(rd, 8'h3C);
        u_wdg_cpu_model.bus_rd(16'h2A00, rd);
        chk(rd, 8'h00);
        $display("test options done");
    endtask
    // every span pair outlasts one fast period, so a missing clear or hold would overflow
    task t_service;
        @(posedge core_clk);
        vector_fetch <= 1'b1;
        @(posedge core_clk);
        vector_fetch <= 1'b0;
        u_wdg_cpu_model.bus_wr(`WDG_ADDR_SERVICE, 8'h5A);
        wait_ticks(4200);
        u_wdg_cpu_model.bus_wr(`WDG_ADDR_SERVICE, 8'h00);
        wait_ticks(4200);
        chk({7'h00, watchdog_reset_flag}, 8'h00);
        @(posedge core_clk);
        monitor_mode <= 1'b1;
        irq_test_voltage <= 1'b1;
        wait_ticks(4200);
        @(posedge core_clk);
        monitor_mode <= 1'b0;
        irq_test_voltage <= 1'b0;
        chk({7'h00, watchdog_reset_flag}, 8'h00);
        wait_ticks(4200);
        @(posedge core_clk);
        break_active <= 1'b1;
        rst_tv <= 1'b1;
        wait_ticks(4200);
        @(posedge core_clk);
        break_active <= 1'b0;
        rst_tv <= 1'b0;
        chk({7'h00, watchdog_reset_flag}, 8'h00);
        $display("test service done");
    endtask
    // fast rate overflow, pin pulse and latch clearing
    task t_overflow;
        int t0;
        int tl;
        u_wdg_cpu_model.bus_wr(`WDG_ADDR_SERVICE, 8'hFF);
        t0 = ticks;
        while (reset_pin_out !== 1'b0 && ticks < t0 + 8300) @(negedge core_clk);
        tl = ticks - t0;
        chk({7'h00, tl >= 8158 && tl <= 8180}, 8'h01);
        chk({7'h00, watchdog_reset_flag}, 8'h01);
        wait_ticks(29);
        chk({7'h00, reset_pin_out}, 8'h00);
        wait_ticks(6);
        chk({7'h00, reset_pin_out}, 8'h01);
        u_wdg_cpu_model.bus_rd(16'h001F, rd);
        chk(rd, 8'h08);
        $display("test overflow done");
    endtask
    // short recovery with clocks kept, then illegal stop after an internal reset
    task t_stop;
        int n;
        u_wdg_cpu_model.bus_wr(16'h001E, 8'h01);
        u_wdg_cpu_model.bus_wr(16'h001F, 8'h0E);
        u_wdg_cpu_model.bus_rd(16'h001F, rd);
        chk(rd, 8'h0E);
        pulse_stop;
        repeat (3) @(negedge core_clk);
        chk({6'h00, stop_mode, gen_clock_run}, 8'h03);
        @(posedge core_clk);
        wake_request <= 1'b1;
        @(posedge core_clk);
        wake_request <= 1'b0;
        n = 0;
        while (stop_exit_done !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, n >= 31 && n <= 36}, 8'h01);
        @(posedge core_clk);
        internal_reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        internal_reset <= 1'b0;
        u_wdg_cpu_model.bus_rd(16'h001F, rd);
        chk(rd, 8'h08);
        pulse_stop;
        @(negedge core_clk);
        chk({7'h00, illegal_stop_reset}, 8'h01);
        $display("test stop done");
    endtask
    // monitor trip in stop forces the long delay; power-down and clocks off in stop
    task t_monitor;
        int n;
        u_wdg_cpu_model.bus_wr(16'h001E, 8'h01);
        u_wdg_cpu_model.bus_wr(16'h001F, 8'h46);
        pulse_stop;
        @(posedge core_clk);
        monitor_trip <= 1'b1;
        n = 0;
        while (stop_exit_done !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, n >= 4090 && n <= 4105}, 8'h01);
        chk({6'h00, monitor_power_on, monitor_reset_req}, 8'h03);
        @(posedge core_clk);
        internal_reset <= 1'b1;
        @(posedge core_clk);
        internal_reset <= 1'b0;
        u_wdg_cpu_model.bus_wr(16'h001F, 8'h32);
        pulse_stop;
        repeat (2) @(negedge core_clk);
        chk({5'h00, stop_mode, gen_clock_run, monitor_power_on}, 8'h04);
        chk({7'h00, monitor_reset_req}, 8'h00);
        $display("test monitor done");
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        t_options;
        t_service;
        t_overflow;
        t_stop;
        t_monitor;
        final_report;
    end
    // hang guard, well past the expected run of about sixty-three thousand cycles
    initial begin
        #2000000;
        mismatches++;
        final_report;
    end
endmodule
bind wdg_top wdg_chk u_wdg_chk (.core_clk(core_clk), .reset(reset), .bus_addr(bus_addr),
    .bus_read(bus_read), .bus_rdata(bus_rdata), .reset_vector_low(reset_vector_low),
    .stop_exec(stop_exec), .stop_mode(stop_mode), .stop_exit_done(stop_exit_done),
    .illegal_stop_reset(illegal_stop_reset), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .watchdog_reset_flag(watchdog_reset_flag));
